// ---- rtl/cam_acceptance_mask.sv ----
// Acceptance mask registers with AHB-Lite slave and identifier match logic
`timescale 1ns/1ps
module cam_acceptance_mask (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic [1:0] hresp_o,
  input wire logic [1:0] mask_sel_i,
  input wire logic [28:0] filter_id_i,
  input wire logic filter_extended_enable_i,
  input wire logic [28:0] msg_id_i,
  input wire logic msg_extended_i,
  output logic match_o
);

  // Mask storage; contents undefined until software writes them
  logic [15:0] mask_standard_id_r [cam_pkg::NUM_MASKS];
  logic [15:0] mask_standard_id_nxt [cam_pkg::NUM_MASKS];
  logic [15:0] mask_extended_id_r [cam_pkg::NUM_MASKS];
  logic [15:0] mask_extended_id_nxt [cam_pkg::NUM_MASKS];
  logic wr_pend_r;
  logic wr_pend_nxt;
  logic [7:0] wr_addr_r;
  logic [7:0] wr_addr_nxt;
  logic [31:0] hrdata_r;
  logic [31:0] hrdata_nxt;
  logic [28:0] care;
  logic [28:0] diff;
  logic [15:0] sel_std;
  logic [15:0] sel_ext;
  logic addr_phase;
  logic [7:0] a_ofs;

  assign addr_phase = hsel_i & hready_i & (htrans_i == cam_pkg::HTRANS_NONSEQ |
                      htrans_i == cam_pkg::HTRANS_SEQ);
  assign a_ofs = haddr_i[7:0];

  // Bus address phase capture and read data
  always_comb begin
    wr_pend_nxt = wr_pend_r;
    wr_addr_nxt = wr_addr_r;
    hrdata_nxt = hrdata_r;
    if (hready_i) begin
      wr_pend_nxt = addr_phase & hwrite_i;
      wr_addr_nxt = a_ofs;
    end
    if (addr_phase & ~hwrite_i) begin
      hrdata_nxt = 32'h0000_0000;
      for (int i = 0; i < cam_pkg::NUM_MASKS; i++) begin
        if (a_ofs == 8'(cam_pkg::MASK_STD_OFS + cam_pkg::MASK_STRIDE * 8'(i))) begin
          // Next value forwards a write landing at this edge to a read right behind it
          hrdata_nxt = {16'h0000, mask_standard_id_nxt[i] & cam_pkg::STD_WMASK};
        end else if (a_ofs == 8'(cam_pkg::MASK_EXT_OFS + cam_pkg::MASK_STRIDE * 8'(i))) begin
          hrdata_nxt = {16'h0000, mask_extended_id_nxt[i]};
        end
      end
      if (haddr_i[31:8] != 24'h000000 || a_ofs >= cam_pkg::MAP_END) begin
        hrdata_nxt = 32'h0000_0000;
      end
    end
  end

  // Mask register writes in the data phase
  always_comb begin
    for (int i = 0; i < cam_pkg::NUM_MASKS; i++) begin
      mask_standard_id_nxt[i] = mask_standard_id_r[i];
      mask_extended_id_nxt[i] = mask_extended_id_r[i];
      if (wr_pend_r) begin
        if (wr_addr_r == 8'(cam_pkg::MASK_STD_OFS + cam_pkg::MASK_STRIDE * 8'(i))) begin
          mask_standard_id_nxt[i] = hwdata_i[15:0] & cam_pkg::STD_WMASK;
        end else if (wr_addr_r == 8'(cam_pkg::MASK_EXT_OFS + cam_pkg::MASK_STRIDE * 8'(i))) begin
          mask_extended_id_nxt[i] = hwdata_i[15:0] & cam_pkg::EXT_WMASK;
        end
      end
    end
  end

  // Bus control state
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  // Mask storage has no reset value
  always_ff @(posedge clk_i) begin
    mask_standard_id_r <= mask_standard_id_nxt;
    mask_extended_id_r <= mask_extended_id_nxt;
  end

  // Select the mask set and build the compare enables
  always_comb begin
    sel_std = 16'h0000;
    sel_ext = 16'h0000;
    for (int i = 0; i < cam_pkg::NUM_MASKS; i++) begin
      if (mask_sel_i == 2'(i)) begin
        sel_std = mask_standard_id_r[i];
        sel_ext = mask_extended_id_r[i];
      end
    end
    // Identifier layout: [28:18] standard, [17:0] extended
    care = {sel_std[cam_pkg::STD_MSB:cam_pkg::STD_LSB],
            sel_std[cam_pkg::EXTHI_MSB:cam_pkg::EXTHI_LSB], sel_ext};
    diff = filter_id_i ^ msg_id_i;
  end

  // Match: every cared bit equal and mask_sel_i selects a mask, frame type checked when mode set
  always_comb begin
    match_o = ((diff & care) == 29'h0000_0000) && (mask_sel_i < 2'(cam_pkg::NUM_MASKS));
    if (sel_std[cam_pkg::MODE_BIT] && (msg_extended_i != filter_extended_enable_i)) begin
      match_o = 1'b0;
    end
    // Mode clear leaves frame type out of the decision
  end

  assign hrdata_o = hrdata_r;
  assign hreadyout_o = 1'b1;
  assign hresp_o = cam_pkg::HRESP_OKAY;

endmodule

// ---- rtl/cam_pkg.sv ----
// Package with register map, field positions and widths of the acceptance mask block
package cam_pkg;
  localparam int NUM_MASKS = 3;
  localparam int STD_W = 11;
  localparam int EXT_W = 18;
  localparam int ID_W = 29;
  // Byte offsets; mask n standard at base + 8n, extended at base + 8n + 4
  localparam logic [7:0] MASK_STD_OFS = 8'h00;
  localparam logic [7:0] MASK_EXT_OFS = 8'h04;
  localparam logic [7:0] MASK_STRIDE = 8'h08;
  localparam logic [7:0] MAP_END = 8'h18;
  // Field positions in the standard mask register
  localparam int STD_LSB = 5;
  localparam int STD_MSB = 15;
  localparam int MODE_BIT = 3;
  localparam int EXTHI_LSB = 0;
  localparam int EXTHI_MSB = 1;
  // Writable bits of the standard and extended mask registers
  localparam logic [15:0] STD_WMASK = 16'hFFEB;
  localparam logic [15:0] EXT_WMASK = 16'hFFFF;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [1:0] HRESP_OKAY = 2'h0;
endpackage

// ---- testbench/cam_checker.sv ----
// Port checker for the mask block
`timescale 1ns/1ps
module cam_checker (input wire logic clk_i, arst_n_i, hwrite_i, hreadyout_o, match_o,
  input wire logic [1:0] htrans_i, hresp_o, mask_sel_i,
  input wire logic [31:0] haddr_i, hwdata_i, hrdata_o);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // Taken transfers
  wire logic rd = htrans_i[1] && !hwrite_i;
  wire logic wr = htrans_i[1] && hwrite_i;
  sequence wb; wr ##1 rd && $stable(haddr_i) && haddr_i < 32'h18; endsequence
  a_no_wait: assert property (hreadyout_o && hresp_o == 2'h0) else $error("wait");
  a_sel_none: assert property (mask_sel_i == 2'h3 |-> !match_o) else $error("set");
  a_high_zero: assert property (rd |=> hrdata_o[31:16] == '0) else $error("high");
  a_map_zero: assert property (rd && haddr_i > 32'h14 |=> hrdata_o == '0)
    else $error("map");
  a_hold_data: assert property (!rd |=> $stable(hrdata_o)) else $error("hold");
  a_gap_zero: assert property (rd && !haddr_i[2] |=> (hrdata_o & 32'h14) == '0)
    else $error("gap");
  a_ext_back: assert property (wb ##0 haddr_i[2] |=>
    hrdata_o[15:0] == $past(hwdata_i[15:0])) else $error("ext");
  a_std_back: assert property (wb ##0 !haddr_i[2] |=>
    hrdata_o[15:0] == ($past(hwdata_i[15:0]) & 16'hFFEB)) else $error("std");
  cover property (wb); cover property (rd); cover property (match_o);
endmodule
bind cam_acceptance_mask cam_checker chk (.*);

// ---- testbench/test_can_acceptance_mask.sv ----
// Bench for the mask block
`timescale 1ns/1ps
module test_can_acceptance_mask;
  logic clk_i = '0, arst_n_i = '0, hsel_i = '1, hready_i = '1, hwrite_i = '0;
  logic filter_extended_enable_i = '0, msg_extended_i = '0, hreadyout_o, match_o;
  logic [1:0] htrans_i = '0, mask_sel_i = '0, hresp_o;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] haddr_i = '0, hwdata_i = '0, hrdata_o;
  logic [28:0] filter_id_i = 29'h15555555, msg_id_i = '0;
  int failures = 0, tests_run = 0;
  cam_acceptance_mask uut (.*);
  // Clock
  initial forever #25 clk_i = ~clk_i;
  task automatic chk(string n, logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin failures++; $display("[ERR] %s exp %h seen %h", n, e, s); end
  endtask
  task automatic nx;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
  endtask
  task automatic acc(logic [31:0] a, d, e);
    nx; htrans_i <= 2'h2; hwrite_i <= '1; haddr_i <= a;
    nx; hwrite_i <= '0; hwdata_i <= d; nx; htrans_i <= '0; nx;
    chk("reg", hrdata_o, e);
  endtask
  task automatic mt(logic [1:0] s, logic [28:0] m, logic f, x, e);
    nx; mask_sel_i <= s; msg_id_i <= m; filter_extended_enable_i <= f; msg_extended_i <= x;
    @(negedge clk_i) chk("match", 32'(match_o), 32'(e));
  endtask
  task automatic t_regs;
    for (int a = 0; a < 32; a += 4) begin
      acc(a, '1, a > 20 ? 32'h0 : a[2] ? 32'hFFFF : 32'hFFEB);
    end
  endtask
  task automatic t_match;
    acc(32'h0, 32'hFFE3, 32'hFFE3); acc(32'h14, 32'hFFFE, 32'hFFFE);
    mt(2'h0, filter_id_i, '0, '1, '1); mt(2'h3, filter_id_i, '0, '0, '0);
    mt(2'h0, filter_id_i ^ 29'h40000, '0, '0, '0);
    mt(2'h0, filter_id_i ^ 29'h10000, '0, '0, '0); mt(2'h2, filter_id_i ^ 29'h1, '0, '0, '1);
    mt(2'h1, filter_id_i, '1, '1, '1); mt(2'h1, filter_id_i, '1, '0, '0);
  endtask
  // Reset, scenarios, verdict
  initial begin
    repeat (10) @(posedge clk_i);
    arst_n_i <= '1;
    t_regs; t_match; report_and_stop;
  end
  // Watchdog
  initial begin #20us; failures++; report_and_stop; end
  task automatic report_and_stop;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
endmodule
